// [rtl/blu_defines.vh]
// Constants for the brightness limit unit: codes, widths and reset values.
// Assumes inclusion by bare name from the rtl folder.
`ifndef BLU_DEFINES_VH
`define BLU_DEFINES_VH

`define BLU_NUM_LIMITS     3
`define BLU_VAL_W          16
`define BLU_FUNC_SWITCH    2'h0
`define BLU_FUNC_LEVEL     2'h1
`define BLU_FUNC_SCENE     2'h2
`define BLU_TEACH_ON_ONE   2'h0
`define BLU_TEACH_ON_ZERO  2'h1
`define BLU_TEACH_ON_BOTH  2'h2
`define BLU_SRC_CONFIG     2'h0
`define BLU_SRC_PRESET     2'h1
`define BLU_SRC_TAUGHT     2'h2
`define BLU_LEVEL_MAX      8'h64
`define BLU_SCENE_MAX      8'h40
`define BLU_ZONE_MID       2'h0
`define BLU_ZONE_ABOVE     2'h1
`define BLU_ZONE_BELOW     2'h2
`define BLU_FB_DELAY_RST   16'h0000

`endif

// [rtl/blu_evaluator.v]
// Brightness limit unit: up to three limits with hysteresis, preset, teach and feedback.
// Assumes all inputs synchronous to i_sys_clk; stored limits survive bus loss because
// i_bus_return only re-arms feedback and never clears them; i_rst_n is power-on only.
`include "blu_defines.vh"
`default_nettype none

module blu_evaluator #(
  parameter N     = `BLU_NUM_LIMITS,
  parameter VAL_W = `BLU_VAL_W,
  parameter DLY_W = 16
) (
  // Clock and reset
  input  wire               i_sys_clk,
  input  wire               i_rst_n,
  // Measured brightness
  input  wire [VAL_W-1:0]   i_brightness,
  input  wire               i_bright_valid,
  // System events
  input  wire               i_reprogram,
  input  wire               i_bus_return,
  input  wire               i_disable,
  // Configuration
  input  wire [1:0]         i_num_active,
  input  wire [N*VAL_W-1:0] i_cfg_limit,
  input  wire [N*VAL_W-1:0] i_cfg_hyst,
  input  wire [N-1:0]       i_limit_is_upper,
  input  wire [N-1:0]       i_send_above,
  input  wire [N-1:0]       i_send_below,
  input  wire [N*2-1:0]     i_func,
  input  wire [N*8-1:0]     i_val_above,
  input  wire [N*8-1:0]     i_val_below,
  input  wire [N*2-1:0]     i_teach_mode,
  input  wire               i_overwrite_on_prog,
  input  wire [N-1:0]       i_fb_active,
  input  wire [DLY_W-1:0]   i_fb_delay,
  // External preset and teach objects
  input  wire [N-1:0]       i_preset_wr,
  input  wire [N*VAL_W-1:0] i_preset_val,
  input  wire [N-1:0]       i_teach_wr,
  input  wire [N-1:0]       i_teach_bit,
  // Output telegrams
  output wire [N-1:0]       o_send,
  output wire [N*2-1:0]     o_kind,
  output wire [N*8-1:0]     o_data,
  // Effective limit feedback and evaluation status
  output reg  [N*VAL_W-1:0] o_eff_limit,
  output reg  [N*2-1:0]     o_limit_src,
  output reg  [N-1:0]       o_fb_send,
  output reg                o_evaluating
);
  reg [DLY_W-1:0] fb_cnt;
  reg             fb_wait;

  // Feedback delay after bus return or reprogramming is shared by all limits.
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fb_cnt  <= `BLU_FB_DELAY_RST;
      fb_wait <= 1'b0;
    end else if (i_bus_return || i_reprogram) begin
      fb_cnt  <= i_fb_delay;
      fb_wait <= 1'b1;
    end else if (fb_wait && fb_cnt != {DLY_W{1'b0}}) begin
      fb_cnt <= fb_cnt - {{(DLY_W-1){1'b0}}, 1'b1};
    end else begin
      fb_wait <= 1'b0;
    end
  end

  wire fb_due;
  assign fb_due = fb_wait && (fb_cnt == {DLY_W{1'b0}});

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_evaluating <= 1'b0;
    end else begin
      o_evaluating <= !i_disable && (i_num_active != 2'h0);
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_lim
      wire [VAL_W-1:0] cfg_lim;
      wire [VAL_W-1:0] upper;
      wire [VAL_W-1:0] lower;
      wire [VAL_W-1:0] cur_lim;
      wire [1:0]       tmode;
      wire             teach_act;
      wire             teach_rst;
      wire             enabled;
      reg  [1:0]       zone;
      reg  [1:0]       next_zone;
      reg              fire;
      reg              fire_above;
      reg              chg;
      reg              prog_seen;

      assign cfg_lim = i_cfg_limit[g*VAL_W +: VAL_W];
      assign tmode   = i_teach_mode[g*2 +: 2];
      assign enabled = (g < i_num_active);
      assign teach_act = i_teach_wr[g] &&
                         ((tmode == `BLU_TEACH_ON_BOTH) ||
                          (tmode == `BLU_TEACH_ON_ONE  &&  i_teach_bit[g]) ||
                          (tmode == `BLU_TEACH_ON_ZERO && !i_teach_bit[g]));
      assign teach_rst = i_teach_wr[g] && !teach_act;
      // Until an external limit exists the configured one is evaluated.
      assign cur_lim = (o_limit_src[g*2 +: 2] == `BLU_SRC_CONFIG) ? cfg_lim :
                       o_eff_limit[g*VAL_W +: VAL_W];

      // Thresholds follow the current limit combinationally, so any new limit
      // takes effect on the next compare.
      blu_thresholds #(
        .VAL_W (VAL_W)
      ) u_thr (
        .i_limit          (cur_lim),
        .i_hyst           (i_cfg_hyst[g*VAL_W +: VAL_W]),
        .i_limit_is_upper (i_limit_is_upper[g]),
        .o_upper          (upper),
        .o_lower          (lower)
      );

      // Limit source; preset and teach are taken whether disabled or not.
      always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          o_limit_src[g*2 +: 2] <= `BLU_SRC_CONFIG;
          o_eff_limit[g*VAL_W +: VAL_W] <= {VAL_W{1'b0}};
          prog_seen <= 1'b0;
          chg <= 1'b0;
        end else begin
          chg <= 1'b0;
          prog_seen <= 1'b1;
          if (teach_act) begin
            o_limit_src[g*2 +: 2] <= `BLU_SRC_TAUGHT;
            o_eff_limit[g*VAL_W +: VAL_W] <= i_brightness;
            chg <= 1'b1;
          end else if (teach_rst) begin
            o_limit_src[g*2 +: 2] <= `BLU_SRC_CONFIG;
            o_eff_limit[g*VAL_W +: VAL_W] <= cfg_lim;
            chg <= 1'b1;
          end else if (i_preset_wr[g]) begin
            o_limit_src[g*2 +: 2] <= `BLU_SRC_PRESET;
            o_eff_limit[g*VAL_W +: VAL_W] <= i_preset_val[g*VAL_W +: VAL_W];
            chg <= 1'b1;
          end else if (i_reprogram && (i_overwrite_on_prog ||
                       o_limit_src[g*2 +: 2] == `BLU_SRC_CONFIG)) begin
            o_limit_src[g*2 +: 2] <= `BLU_SRC_CONFIG;
            o_eff_limit[g*VAL_W +: VAL_W] <= cfg_lim;
          end else if (!prog_seen ||
                       o_limit_src[g*2 +: 2] == `BLU_SRC_CONFIG) begin
            o_eff_limit[g*VAL_W +: VAL_W] <= cfg_lim;
          end
        end
      end

      // Zone tracking with hysteresis; a telegram leaves only on zone entry.
      always @* begin
        next_zone  = zone;
        fire       = 1'b0;
        fire_above = 1'b0;
        if (i_bright_valid && enabled && !i_disable) begin
          if (i_brightness > upper && zone != `BLU_ZONE_ABOVE) begin
            next_zone  = `BLU_ZONE_ABOVE;
            fire       = i_send_above[g];
            fire_above = 1'b1;
          end else if (i_brightness < lower && zone != `BLU_ZONE_BELOW) begin
            next_zone = `BLU_ZONE_BELOW;
            fire      = i_send_below[g];
          end
        end
      end

      always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          zone <= `BLU_ZONE_MID;
        end else if (i_disable || !enabled || i_reprogram) begin
          zone <= `BLU_ZONE_MID;
        end else begin
          zone <= next_zone;
        end
      end

      blu_telegram u_tel (
        .i_sys_clk   (i_sys_clk),
        .i_rst_n     (i_rst_n),
        .i_fire      (fire),
        .i_above     (fire_above),
        .i_func      (i_func[g*2 +: 2]),
        .i_val_above (i_val_above[g*8 +: 8]),
        .i_val_below (i_val_below[g*8 +: 8]),
        .o_send      (o_send[g]),
        .o_kind      (o_kind[g*2 +: 2]),
        .o_data      (o_data[g*8 +: 8])
      );

      // Feedback pulse, one cycle after a teach or preset write changed the limit register, or when the shared feedback delay expires.
      always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          o_fb_send[g] <= 1'b0;
        end else begin
          o_fb_send[g] <= i_fb_active[g] && enabled && (chg || fb_due);
        end
      end
    end
  endgenerate
endmodule // blu_evaluator

`default_nettype wire

// [rtl/blu_telegram.v]
// Output telegram encoder for one limit: selects switch, level or scene payload.
// Assumes event pulses come from the evaluator and payload settings are static.
`include "blu_defines.vh"
`default_nettype none

module blu_telegram (
  // Clock and reset
  input  wire       i_sys_clk,
  input  wire       i_rst_n,
  // Event
  input  wire       i_fire,
  input  wire       i_above,
  // Configuration
  input  wire [1:0] i_func,
  input  wire [7:0] i_val_above,
  input  wire [7:0] i_val_below,
  // Telegram
  output reg        o_send,
  output reg  [1:0] o_kind,
  output reg  [7:0] o_data
);
  reg [7:0] pick;
  reg [7:0] next_data;

  always @* begin
    pick = i_above ? i_val_above : i_val_below;
    case (i_func)
      `BLU_FUNC_SWITCH: next_data = {7'h00, pick[0]};
      `BLU_FUNC_LEVEL:  next_data = (pick > `BLU_LEVEL_MAX) ? `BLU_LEVEL_MAX : pick;
      `BLU_FUNC_SCENE:  next_data = (pick > `BLU_SCENE_MAX) ? `BLU_SCENE_MAX : pick;
      default:          next_data = 8'h00;
    endcase
  end

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_send <= 1'b0;
      o_kind <= 2'h0;
      o_data <= 8'h00;
    end else begin
      o_send <= i_fire;
      if (i_fire) begin
        o_kind <= i_func;
        o_data <= next_data;
      end
    end
  end
endmodule // blu_telegram

`default_nettype wire

// [rtl/blu_thresholds.v]
// Threshold derivation for one limit: limit plus or minus the fixed hysteresis.
// Assumes limit and hysteresis are unsigned codes of monotonic brightness scale.
`default_nettype none

module blu_thresholds #(
  parameter VAL_W = 16
) (
  // Inputs
  input  wire [VAL_W-1:0] i_limit,
  input  wire [VAL_W-1:0] i_hyst,
  input  wire             i_limit_is_upper,
  // Outputs
  output wire [VAL_W-1:0] o_upper,
  output wire [VAL_W-1:0] o_lower
);
  wire [VAL_W:0] sum;
  wire [VAL_W:0] dif;

  assign sum = {1'b0, i_limit} + {1'b0, i_hyst};
  assign dif = {1'b0, i_limit} - {1'b0, i_hyst};
  // Results saturate so that a large hysteresis cannot wrap the scale.
  assign o_upper = i_limit_is_upper ? i_limit :
                   (sum[VAL_W] ? {VAL_W{1'b1}} : sum[VAL_W-1:0]);
  assign o_lower = i_limit_is_upper ?
                   (dif[VAL_W] ? {VAL_W{1'b0}} : dif[VAL_W-1:0]) : i_limit;
endmodule // blu_thresholds

`default_nettype wire

// [sim/blu_checker.sv]
// Checker for the brightness limit evaluator, bound to its ports.
// Assumes the default widths and one clock domain.
`include "blu_defines.vh"
`default_nettype none
module blu_checker #(
  parameter N     = 3,
  parameter VAL_W = 16
) (
  // Clock, reset and events
  input wire logic               i_sys_clk,
  input wire logic               i_rst_n,
  input wire logic [VAL_W-1:0]   i_brightness,
  input wire logic               i_disable,
  input wire logic               i_reprogram,
  input wire logic               i_overwrite_on_prog,
  // Configuration and objects
  input wire logic [1:0]         i_num_active,
  input wire logic [N*VAL_W-1:0] i_cfg_limit,
  input wire logic [N*2-1:0]     i_teach_mode,
  input wire logic [N-1:0]       i_fb_active,
  input wire logic [N-1:0]       i_preset_wr,
  input wire logic [N*VAL_W-1:0] i_preset_val,
  input wire logic [N-1:0]       i_teach_wr,
  input wire logic [N-1:0]       i_teach_bit,
  // Outputs
  input wire logic [N-1:0]       o_send,
  input wire logic [N*2-1:0]     o_kind,
  input wire logic [N*8-1:0]     o_data,
  input wire logic [N*VAL_W-1:0] o_eff_limit,
  input wire logic [N*2-1:0]     o_limit_src,
  input wire logic [N-1:0]       o_fb_send
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  send_once_a: assert property (o_send[0] && $stable(i_brightness) && !$past(i_reprogram)
    |=> !o_send[0]) else $error("telegram pulse repeated");
  disable_quiet_a: assert property (i_disable |=> o_send == '0)
    else $error("telegram while disabled");
  inactive_quiet_a: assert property (i_num_active == 2'h1 |=> o_send[2:1] == 2'b00)
    else $error("inactive limit sent");
  preset_load_a: assert property (i_preset_wr[0] && !i_teach_wr[0] |=>
    o_eff_limit[15:0] == $past(i_preset_val[15:0]) && o_limit_src[1:0] == `BLU_SRC_PRESET)
    else $error("preset not adopted");
  teach_take_a: assert property (i_teach_wr[0] && i_teach_bit[0] && i_teach_mode[1:0] == 2'h0
    |=> o_eff_limit[15:0] == $past(i_brightness))
    else $error("teach did not capture");
  teach_restore_a: assert property (i_teach_wr[0] && !i_teach_bit[0] && i_teach_mode[1:0] == 2'h0
    |=> o_eff_limit[15:0] == $past(i_cfg_limit[15:0]))
    else $error("teach inactive did not restore");
  feedback_pulse_a: assert property (i_preset_wr[0] && !i_teach_wr[0] && i_fb_active[0] &&
    i_num_active != 2'h0 && i_preset_val[15:0] != o_eff_limit[15:0] |=> ##1 o_fb_send[0])
    else $error("feedback missing");
  level_range_a: assert property (o_send[0] && o_kind[1:0] == `BLU_FUNC_LEVEL |->
    o_data[7:0] <= `BLU_LEVEL_MAX) else $error("level out of range");
  scene_range_a: assert property (o_send[0] && o_kind[1:0] == `BLU_FUNC_SCENE |->
    o_data[7:0] <= `BLU_SCENE_MAX) else $error("scene out of range");
  reprog_keep_a: assert property (i_reprogram && !i_overwrite_on_prog && !i_preset_wr[0] &&
    !i_teach_wr[0] && o_limit_src[1:0] != `BLU_SRC_CONFIG |=> $stable(o_eff_limit[15:0]))
    else $error("limit lost on reprogram");
  cover property (o_send[0]);
  cover property (o_fb_send[0]);
  cover property (i_teach_wr[0] && i_disable);
endmodule // blu_checker
bind blu_evaluator blu_checker #(.N(N), .VAL_W(VAL_W)) blu_checker_i (.*);
`default_nettype wire

// [sim/blu_listener.sv]
// Model of a bus subscriber that receives the first limit's telegrams.
// Assumes one-cycle send pulses sampled on the rising edge.
`default_nettype none
module blu_listener (
  // Clock and telegram
  input  wire logic       i_sys_clk,
  input  wire logic       i_send,
  input  wire logic [7:0] i_data,
  // Received record
  output var  logic [7:0] o_count,
  output var  logic [7:0] o_last
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_count = 8'h00;
  always @(posedge i_sys_clk) begin
    if (i_send) begin
      o_count <= o_count + 8'h01;
      o_last  <= i_data;
    end
  end
endmodule // blu_listener
`default_nettype wire

// [sim/tb.sv]
// Testbench for the brightness limit evaluator with a telegram listener.
// Assumes the checker is bound by its own file.
`include "blu_defines.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [1:0] func; logic up; logic [15:0] br; logic fire; logic [7:0] dat;} blu_row_t;
  logic        i_sys_clk, i_rst_n, i_bright_valid, i_reprogram, i_bus_return, i_disable;
  logic        i_overwrite_on_prog, o_evaluating, seen;
  logic [15:0] i_brightness, i_fb_delay;
  logic [1:0]  i_num_active;
  logic [47:0] i_cfg_limit, i_cfg_hyst, i_preset_val, o_eff_limit;
  logic [2:0]  i_limit_is_upper, i_send_above, i_send_below, i_fb_active, i_preset_wr;
  logic [2:0]  i_teach_wr, i_teach_bit, o_send, o_fb_send;
  logic [5:0]  i_func, i_teach_mode, o_kind, o_limit_src;
  logic [23:0] i_val_above, i_val_below, o_data;
  logic [7:0]  heard, heard_data, msk;
  int          errors = 0, samples_checked = 0, cycles = 0;
  blu_row_t    rows [8];
  blu_evaluator #(.N(3), .VAL_W(16), .DLY_W(16)) blu_evaluator_i (.*);
  blu_listener blu_listener_i (.i_sys_clk(i_sys_clk), .i_send(o_send[0]), .i_data(o_data[7:0]),
    .o_count(heard), .o_last(heard_data));
  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors = errors + 1;
      results();
    end
  end
  task automatic results();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("MISMATCH %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic pulse_teach(input logic b);
    i_teach_bit[0] = b;
    i_teach_wr[0] = 1'b1;
    step(1);
    i_teach_wr[0] = 1'b0;
    step(1);
  endtask
  initial begin
    {i_rst_n, i_reprogram, i_bus_return, i_disable, i_overwrite_on_prog} = '0;
    {i_preset_wr, i_preset_val, i_teach_wr, i_teach_bit, i_func, i_teach_mode} = '0;
    {i_bright_valid, i_num_active, i_brightness, i_fb_delay} = {1'b1, 2'h1, 16'h0F80, 16'h0003};
    {i_limit_is_upper, i_send_above, i_send_below, i_fb_active} = '1;
    {i_cfg_limit, i_cfg_hyst} = {48'h5000_4000_1000, 48'h0100_0100_0100};
    {i_val_above, i_val_below} = {24'hC9C9_C9, 24'h0505_05};
    rows = '{{2'h0, 1'b1, 16'h1001, 1'b1, 8'h01}, {2'h0, 1'b1, 16'h1000, 1'b0, 8'h00},
             {2'h0, 1'b1, 16'h0EFF, 1'b1, 8'h01}, {2'h1, 1'b1, 16'h1001, 1'b1, 8'h64},
             {2'h1, 1'b0, 16'h1101, 1'b1, 8'h64}, {2'h1, 1'b0, 16'h1100, 1'b0, 8'h00},
             {2'h2, 1'b1, 16'h1001, 1'b1, 8'h40}, {2'h2, 1'b0, 16'h0FFF, 1'b1, 8'h05}};
    step(5);
    check({o_send, o_fb_send, o_evaluating}, 16'h0000);
    i_rst_n = 1'b1;
    step(2);
    check(o_eff_limit[15:0], 16'h1000);
    check(o_evaluating, 1'b1);
    foreach (rows[k]) begin
      {i_func[1:0], i_limit_is_upper[0], i_disable} = {rows[k].func, rows[k].up, 1'b1};
      i_brightness = rows[k].up ? 16'h0F80 : 16'h1080;
      step(2);
      i_disable = 1'b0;
      step(2);
      i_brightness = rows[k].br;
      step(1);
      msk = (rows[k].func == `BLU_FUNC_SWITCH) ? 8'h01 : 8'hFF;
      check(o_send[0], rows[k].fire);
      if (rows[k].fire) check(o_data[7:0] & msk, rows[k].dat);
      if (rows[k].fire) check(o_kind[1:0], rows[k].func);
      step(1);
      check(o_send[0], 1'b0);
      $display("row %0d done", k);
    end
    check(heard, 8'h06);
    i_disable = 1'b1;
    {i_preset_val[15:0], i_preset_wr[0]} = {16'h2000, 1'b1};
    step(1);
    i_preset_wr[0] = 1'b0;
    check({o_eff_limit[15:0], o_limit_src[1:0]}, {16'h2000, `BLU_SRC_PRESET});
    step(1);
    check(o_fb_send[0], 1'b1);
    i_brightness = 16'h3000;
    pulse_teach(1'b1);
    check({o_eff_limit[15:0], o_limit_src[1:0]}, {16'h3000, `BLU_SRC_TAUGHT});
    i_brightness = 16'h3100;
    pulse_teach(1'b1);
    check(o_eff_limit[15:0], 16'h3100);
    {i_bus_return, seen} = 2'b10;
    repeat (8) begin
      step(1);
      i_bus_return = 1'b0;
      seen = seen | o_fb_send[0];
    end
    check({seen, o_eff_limit[15:0]}, {1'b1, 16'h3100});
    i_reprogram = 1'b1;
    step(1);
    i_reprogram = 1'b0;
    check(o_eff_limit[15:0], 16'h3100);
    pulse_teach(1'b0);
    check({o_eff_limit[15:0], o_limit_src[1:0]}, {16'h1000, `BLU_SRC_CONFIG});
    i_teach_mode[1:0] = `BLU_TEACH_ON_BOTH;
    pulse_teach(1'b0);
    check(o_eff_limit[15:0], 16'h3100);
    {i_overwrite_on_prog, i_reprogram} = 2'b11;
    step(1);
    i_reprogram = 1'b0;
    check(o_eff_limit[15:0], 16'h1000);
    seen = 1'b0;
    repeat (8) begin
      step(1);
      seen = seen | o_fb_send[0];
    end
    check(seen, 1'b1);
    i_teach_mode[1:0] = `BLU_TEACH_ON_ZERO;
    i_brightness = 16'h3200;
    pulse_teach(1'b0);
    check({o_eff_limit[15:0], o_limit_src[1:0]}, {16'h3200, `BLU_SRC_TAUGHT});
    pulse_teach(1'b1);
    check({o_eff_limit[15:0], o_limit_src[1:0]}, {16'h1000, `BLU_SRC_CONFIG});
    check(o_evaluating, 1'b0);
    check(heard, 8'h06);
    check(heard_data, 8'h05);
    $display("limit object tests done");
    results();
  end
endmodule // tb
`default_nettype wire
